// ---- core/config_memory_crc_monitor.sv ----
// Configuration memory CRC monitor with AXI4-Lite registers and serial read-out
//
// How it works
// - Checking starts by itself once enabled and user mode is entered.
// - Error flag stays low until a finished pass finds corruption.
// - A raised flag stays high through the whole following pass.
// - A clean pass drops the flag at its end; flag shows latest pass.
// - Passes repeat back to back until device reset.
// - Check clock is the oscillator through a selectable divider.
// - Divider is two to the power 0 to 8, so 1 to 256.
// - Check rate spans 80 MHz down to 312.5 kHz.
// - Pass length grows with memory size and divider setting.
// - Signature sits in a 32-bit register readable by core logic.
// - When enabled, the error flag drives the dual-purpose error pin.
// - Secure low-power variant always drives the error pin open drain.
// - Shift high shifts read-out register one bit per user clock rise.
// - Shift low loads: select 0 precomputed CRC, 1 signature.
// - Error flag is timed by the check clock, not the user clock.
// - Nonzero signature means corruption; zero means clean.
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module config_memory_crc_monitor
    import crc_monitor_pkg::*;
#(
    parameter int CFG_WORDS      = 1024,
    parameter int CFG_ADDR_W     = 16,
    parameter bit SECURE_VARIANT = 1'b0
) (
    input  wire logic                  clock_i,
    input  wire logic                  resetn_i,
    input  wire logic                  ce_i,
    input  wire logic                  user_mode_i,
    output logic      [CFG_ADDR_W-1:0] cfg_addr_o,
    input  wire logic [31:0]           cfg_data_i,
    input  wire logic                  read_clk_i,
    input  wire logic                  shift_not_load_i,
    input  wire logic                  load_select_i,
    output logic                       shift_out_o,
    output logic                       error_pin_o,
    output logic                       error_pin_oe_o,
    output logic                       irq_o,
    input  wire logic [11:0]           s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic      [1:0]            s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [11:0]           s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic      [31:0]           s_axi_rdata,
    output logic      [1:0]            s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready
);

    initial begin
        if (CFG_WORDS < 2 || CFG_WORDS > (2 ** CFG_ADDR_W) || CFG_ADDR_W > 24)
            $error("config_memory_crc_monitor: CFG_WORDS does not fit CFG_ADDR_W");
    end

    // ***************************************************************
    // CRC over one 32-bit word, MSB first
    // ***************************************************************
    function automatic logic [31:0] crc_word(input logic [31:0] crc, input logic [31:0] d);
        logic [31:0] c;
        c = crc;
        for (int i = 31; i >= 0; i--) begin
            c = (c[31] ^ d[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) r[8*b +: 8] = d[8*b +: 8];
        end
        return r;
    endfunction

    // ***************************************************************
    // State
    // ***************************************************************
    check_state_t           state_reg;
    logic [CFG_ADDR_W-1:0]  addr_reg;
    logic [31:0]            crc_reg;
    logic [31:0]            signature_reg;
    logic [31:0]            precomp_reg;
    logic                   flag_reg;
    logic                   first_done_reg;
    logic [DIV_CNT_W-1:0]   div_cnt_reg;
    logic                   enable_reg;
    logic                   open_drain_reg;
    logic [CTRL_DIV_W-1:0]  div_exp_reg;
    logic [IRQ_W-1:0]       irq_status_reg;
    logic [IRQ_W-1:0]       irq_mask_reg;
    logic                   irq_reg;
    logic [31:0]            shift_reg;
    logic                   read_clk_d_reg;
    logic                   pin_reg;
    logic                   pin_oe_reg;
    logic                   aw_rdy_reg;
    logic                   w_rdy_reg;
    logic [11:0]            aw_addr_reg;
    logic [31:0]            w_data_reg;
    logic [3:0]             w_strb_reg;
    logic                   bvalid_reg;
    logic [1:0]             bresp_reg;
    logic                   ar_rdy_reg;
    logic                   rvalid_reg;
    logic [1:0]             rresp_reg;
    logic [31:0]            rdata_reg;

    // ***************************************************************
    // Check clock divider
    // ***************************************************************
    wire [DIV_CNT_W-1:0] div_mask  = DIV_CNT_W'((9'h001 << div_exp_reg) - 9'h001);
    wire                 tick      = ce_i && ((div_cnt_reg & div_mask) == div_mask);
    wire                 last_word = (addr_reg == CFG_ADDR_W'(CFG_WORDS - 1));
    wire [31:0]          crc_step  = crc_word(crc_reg, cfg_data_i);
    wire [31:0]          sig_next  = crc_reg ^ precomp_reg;
    wire                 start     = (state_reg == ST_IDLE) && enable_reg && user_mode_i;
    wire                 pass_end  = (state_reg == ST_DONE) && tick;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_cnt_reg <= '0;
        end else if (ce_i) begin
            div_cnt_reg <= div_cnt_reg + 8'h01;
        end
    end

    // ***************************************************************
    // Pass sequencer
    // ***************************************************************
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg      <= ST_IDLE;
            addr_reg       <= '0;
            crc_reg        <= CRC_SEED;
            signature_reg  <= '0;
            flag_reg       <= 1'b0;
            first_done_reg <= 1'b0;
        end else if (tick) begin
            case (state_reg)
                ST_IDLE: begin
                    if (start) begin
                        addr_reg  <= '0;
                        crc_reg   <= CRC_SEED;
                        state_reg <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    crc_reg <= crc_step;
                    if (last_word) begin
                        state_reg <= ST_DONE;
                    end else begin
                        addr_reg <= addr_reg + 1'b1;
                    end
                end
                ST_DONE: begin
                    signature_reg  <= sig_next;
                    flag_reg       <= |sig_next;
                    first_done_reg <= 1'b1;
                    addr_reg       <= '0;
                    crc_reg        <= CRC_SEED;
                    state_reg      <= ST_RUN;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ***************************************************************
    // Serial read-out on the user read clock
    // ***************************************************************
    wire        read_rise = ce_i && read_clk_i && !read_clk_d_reg;
    wire [31:0] load_word = load_select_i ? signature_reg : precomp_reg;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            read_clk_d_reg <= 1'b0;
            shift_reg      <= '0;
        end else if (ce_i) begin
            read_clk_d_reg <= read_clk_i;
            if (read_rise) begin
                shift_reg <= shift_not_load_i ? {1'b0, shift_reg[31:1]}
                                              : load_word;
            end
        end
    end

    // ***************************************************************
    // Error pin
    // ***************************************************************
    wire use_od = SECURE_VARIANT || open_drain_reg;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_reg    <= 1'b0;
            pin_oe_reg <= 1'b0;
        end else if (ce_i) begin
            pin_reg    <= use_od ? 1'b0 : flag_reg;
            pin_oe_reg <= enable_reg && (use_od ? !flag_reg : 1'b1);
        end
    end

    // ***************************************************************
    // Interrupts
    // ***************************************************************
    wire             wr_fire   = aw_rdy_reg == 1'b0 && w_rdy_reg == 1'b0 && !bvalid_reg;
    wire             wr_irq    = wr_fire && (aw_addr_reg == IRQ_STATUS_OFFSET);
    wire [IRQ_W-1:0] irq_set   = {pass_end && |sig_next, pass_end};
    wire [IRQ_W-1:0] irq_clr   = wr_irq && w_strb_reg[0] ? w_data_reg[IRQ_W-1:0] : '0;
    wire [IRQ_W-1:0] irq_next  = (irq_status_reg & ~irq_clr) | irq_set;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_status_reg <= '0;
            irq_reg        <= 1'b0;
        end else if (ce_i) begin
            irq_status_reg <= irq_next;
            irq_reg        <= |(irq_next & irq_mask_reg);
        end
    end

    // ***************************************************************
    // AXI4-Lite write channel
    // ***************************************************************
    wire [31:0] ctrl_word = {24'h0, div_exp_reg, 2'b00, open_drain_reg, enable_reg};
    wire [31:0] ctrl_new  = merge(ctrl_word, w_data_reg, w_strb_reg);
    wire        div_ok    = ctrl_new[CTRL_DIV_LSB +: CTRL_DIV_W] <= CTRL_DIV_W'(DIV_EXP_MAX);
    wire        wr_known  = aw_addr_reg == CTRL_OFFSET || aw_addr_reg == STATUS_OFFSET
                         || aw_addr_reg == SIGNATURE_OFFSET || aw_addr_reg == PRECOMP_OFFSET
                         || aw_addr_reg == IRQ_STATUS_OFFSET || aw_addr_reg == IRQ_MASK_OFFSET;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            aw_rdy_reg     <= 1'b1;
            w_rdy_reg      <= 1'b1;
            aw_addr_reg    <= '0;
            w_data_reg     <= '0;
            w_strb_reg     <= '0;
            bvalid_reg     <= 1'b0;
            bresp_reg      <= RESP_OKAY;
            enable_reg     <= CTRL_RESET[CTRL_ENABLE_BIT];
            open_drain_reg <= CTRL_RESET[CTRL_OPEN_DRAIN_BIT];
            div_exp_reg    <= CTRL_RESET[CTRL_DIV_LSB +: CTRL_DIV_W];
            precomp_reg    <= PRECOMP_RESET;
            irq_mask_reg   <= '0;
        end else if (ce_i) begin
            if (aw_rdy_reg && s_axi_awvalid) begin
                aw_rdy_reg  <= 1'b0;
                aw_addr_reg <= {s_axi_awaddr[11:2], 2'b00};
            end
            if (w_rdy_reg && s_axi_wvalid) begin
                w_rdy_reg  <= 1'b0;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_known ? RESP_OKAY : RESP_SLVERR;
                if (aw_addr_reg == CTRL_OFFSET) begin
                    enable_reg     <= ctrl_new[CTRL_ENABLE_BIT];
                    open_drain_reg <= ctrl_new[CTRL_OPEN_DRAIN_BIT];
                    if (div_ok) div_exp_reg <= ctrl_new[CTRL_DIV_LSB +: CTRL_DIV_W];
                end
                if (aw_addr_reg == PRECOMP_OFFSET) begin
                    precomp_reg <= merge(precomp_reg, w_data_reg, w_strb_reg);
                end
                if (aw_addr_reg == IRQ_MASK_OFFSET && w_strb_reg[0]) begin
                    irq_mask_reg <= w_data_reg[IRQ_W-1:0];
                end
            end
            if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
                aw_rdy_reg <= 1'b1;
                w_rdy_reg  <= 1'b1;
            end
        end
    end

    // ***************************************************************
    // AXI4-Lite read channel
    // ***************************************************************
    wire [11:0] ra         = {s_axi_araddr[11:2], 2'b00};
    wire [31:0] status_word = {29'h0, first_done_reg, state_reg != ST_IDLE, flag_reg};
    wire        rd_known   = ra == CTRL_OFFSET || ra == STATUS_OFFSET || ra == SIGNATURE_OFFSET
                          || ra == PRECOMP_OFFSET || ra == IRQ_STATUS_OFFSET
                          || ra == IRQ_MASK_OFFSET;
    wire [31:0] rd_word    = ra == CTRL_OFFSET       ? ctrl_word
                           : ra == STATUS_OFFSET     ? status_word
                           : ra == SIGNATURE_OFFSET  ? signature_reg
                           : ra == PRECOMP_OFFSET    ? precomp_reg
                           : ra == IRQ_STATUS_OFFSET ? {30'h0, irq_status_reg}
                           : ra == IRQ_MASK_OFFSET   ? {30'h0, irq_mask_reg}
                           : 32'h0000_0000;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ar_rdy_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rresp_reg  <= RESP_OKAY;
            rdata_reg  <= '0;
        end else if (ce_i) begin
            if (ar_rdy_reg && s_axi_arvalid) begin
                ar_rdy_reg <= 1'b0;
                rvalid_reg <= 1'b1;
                rdata_reg  <= rd_word;
                rresp_reg  <= rd_known ? RESP_OKAY : RESP_SLVERR;
            end
            if (rvalid_reg && s_axi_rready) begin
                rvalid_reg <= 1'b0;
                ar_rdy_reg <= 1'b1;
            end
        end
    end

    assign cfg_addr_o     = addr_reg;
    assign shift_out_o    = shift_reg[0];
    assign error_pin_o    = pin_reg;
    assign error_pin_oe_o = pin_oe_reg;
    assign irq_o          = irq_reg;
    assign s_axi_awready  = aw_rdy_reg;
    assign s_axi_wready   = w_rdy_reg;
    assign s_axi_bvalid   = bvalid_reg;
    assign s_axi_bresp    = bresp_reg;
    assign s_axi_arready  = ar_rdy_reg;
    assign s_axi_rvalid   = rvalid_reg;
    assign s_axi_rresp    = rresp_reg;
    assign s_axi_rdata    = rdata_reg;

    // ***************************************************************
    // Assertions
    // ***************************************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i || !ce_i);

    sequence s_pass_end;
        (state_reg == ST_DONE) && tick;
    endsequence

    sequence s_new_pass;
        ##1 (state_reg == ST_RUN) && (addr_reg == '0) && (crc_reg == CRC_SEED);
    endsequence

    a_flag_before_first: assert property (!first_done_reg |-> !flag_reg)
        else $error("error flag high before first pass completed");

    a_flag_held_pass: assert property ($changed(flag_reg) |-> $past(pass_end))
        else $error("error flag changed outside a pass end");

    a_flag_from_sig: assert property (s_pass_end |=> flag_reg == |signature_reg)
        else $error("error flag does not match signature");

    a_pass_repeat: assert property (s_pass_end |-> s_new_pass)
        else $error("next pass did not start");

    a_auto_start: assert property (start && tick |=> state_reg == ST_RUN)
        else $error("checking did not start in user mode");

    a_div_tick: assert property (tick && div_exp_reg != '0
                                 |=> !tick && div_exp_reg <= CTRL_DIV_W'(DIV_EXP_MAX))
        else $error("check tick off divider boundary");

    a_shift_step: assert property (read_rise && shift_not_load_i
                                   |=> shift_reg[30:0] == $past(shift_reg[31:1]))
        else $error("read-out register did not shift");

    a_load_source: assert property (read_rise && !shift_not_load_i
                                    |=> shift_reg == $past(load_word))
        else $error("read-out register loaded wrong source");

    a_pin_route: assert property (!enable_reg ##1 !enable_reg |-> !error_pin_oe_o)
        else $error("error pin driven while disabled");

    a_secure_od: assert property (use_od && enable_reg ##1 enable_reg
                                  |-> !error_pin_o && (error_pin_oe_o == !$past(flag_reg)))
        else $error("secure variant error pin not open drain");

endmodule

`default_nettype wire

// ---- core/crc_monitor_pkg.sv ----
// Constants shared by the configuration memory CRC monitor
package crc_monitor_pkg;

    // ***************************************************************
    // Register map (byte addresses)
    // ***************************************************************
    localparam logic [11:0] CTRL_OFFSET       = 12'h000;
    localparam logic [11:0] STATUS_OFFSET     = 12'h004;
    localparam logic [11:0] SIGNATURE_OFFSET  = 12'h008;
    localparam logic [11:0] PRECOMP_OFFSET    = 12'h00c;
    localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h010;
    localparam logic [11:0] IRQ_MASK_OFFSET   = 12'h014;

    // ***************************************************************
    // Field positions
    // ***************************************************************
    localparam int CTRL_ENABLE_BIT     = 0;
    localparam int CTRL_OPEN_DRAIN_BIT = 1;
    localparam int CTRL_DIV_LSB        = 4;
    localparam int CTRL_DIV_W          = 4;
    localparam int STATUS_FLAG_BIT     = 0;
    localparam int STATUS_BUSY_BIT     = 1;
    localparam int STATUS_FIRST_BIT    = 2;
    localparam int IRQ_PASS_BIT        = 0;
    localparam int IRQ_ERROR_BIT       = 1;
    localparam int IRQ_W               = 2;

    // ***************************************************************
    // Reset values and encodings
    // ***************************************************************
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
    localparam logic [31:0] PRECOMP_RESET  = 32'h0000_0000;
    localparam logic [31:0] CRC_SEED       = 32'hffff_ffff;
    localparam logic [31:0] CRC_POLY       = 32'h04c1_1db7;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // ***************************************************************
    // Check clock: oscillator divided by two to the power 0..8
    // ***************************************************************
    localparam int OSC_FREQ_HZ       = 80_000_000;
    localparam int CHECK_FREQ_MIN_HZ = 312_500;
    localparam int DIV_EXP_MAX       = 8;
    localparam int DIV_MAX           = OSC_FREQ_HZ / CHECK_FREQ_MIN_HZ;
    localparam int DIV_CNT_W         = 8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN  = 3'b010,
        ST_DONE = 3'b100
    } check_state_t;

endpackage

// ---- verification/crc_core_partner.sv ----
// Configuration memory and core-logic signature reader facing the monitor
`timescale 1ns/100ps
`default_nettype none
module crc_core_partner #(
    parameter int WORDS  = 4,
    parameter int ADDR_W = 16
) (
    input  wire logic              clock_i,
    input  wire logic [ADDR_W-1:0] cfg_addr_i,
    output logic      [31:0]       cfg_data_o,
    input  wire logic              shift_out_i,
    output logic                   read_clk_o = 1'h0,
    output logic                   shift_not_load_o = 1'h1,
    output logic                   load_select_o = 1'h0
);
    logic [31:0] mem [WORDS];
    assign cfg_data_o = mem[cfg_addr_i[$clog2(WORDS)-1:0]];
    // One load edge then 31 shift edges; bits are sampled into v LSB first
    task automatic read_word(input logic sel, output logic [31:0] v);
        for (int i = 0; i < 32; i++) begin
            @(posedge clock_i);
            read_clk_o <= 1'h1;
            shift_not_load_o <= (i != 0);
            load_select_o <= sel;
            @(posedge clock_i);
            read_clk_o <= 1'h0;
            repeat (2) @(posedge clock_i);
            @(negedge clock_i);
            v[i] = shift_out_i;
        end
    endtask
endmodule
`default_nettype wire

// ---- verification/config_memory_crc_monitor_tb.sv ----
// Self-checking bench for the configuration memory CRC monitor
`timescale 1ns/100ps
`default_nettype none
module config_memory_crc_monitor_tb;
    import crc_monitor_pkg::*;
    localparam int WORDS = 4;
    logic clock_i = 1'h0, resetn_i = 1'h0, ce_i = 1'h1, user_mode_i = 1'h0;
    logic [15:0] cfg_addr_o, a0;
    logic [31:0] cfg_data_i, s_axi_wdata = '0, s_axi_rdata, v, pre, fix;
    logic read_clk_i, shift_not_load_i, load_select_i, shift_out_o;
    logic error_pin_o, error_pin_oe_o, irq_o, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [3:0]  s_axi_wstrb = 4'hf, n;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    int          fail_count = 0;
    int          tests_run = 0;
    int          k, m, c;
    always #4 clock_i = ~clock_i;
    config_memory_crc_monitor #(.CFG_WORDS(WORDS)) u_dut (.clock_i, .resetn_i, .ce_i,
        .user_mode_i, .cfg_addr_o, .cfg_data_i, .read_clk_i, .shift_not_load_i,
        .load_select_i, .shift_out_o, .error_pin_o, .error_pin_oe_o, .irq_o,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    crc_core_partner #(.WORDS(WORDS)) u_core (.clock_i(clock_i), .cfg_addr_i(cfg_addr_o),
        .cfg_data_o(cfg_data_i), .shift_out_i(shift_out_o), .read_clk_o(read_clk_i),
        .shift_not_load_o(shift_not_load_i), .load_select_o(load_select_i));
    task automatic results();
        if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic hang();
        fail_count++;
        results();
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] rsp);
        logic aw, w, b;
        @(posedge clock_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (int i = 0; i < 40; i++) begin
            @(negedge clock_i);
            aw = s_axi_awvalid & s_axi_awready;
            w = s_axi_wvalid & s_axi_wready;
            b = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge clock_i);
            if (aw) s_axi_awvalid <= 1'h0;
            if (w) s_axi_wvalid <= 1'h0;
            if (b) begin
                s_axi_bready <= 1'h0;
                return;
            end
        end
        hang();
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rsp);
        logic ar, b;
        @(posedge clock_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (int i = 0; i < 40; i++) begin
            @(negedge clock_i);
            ar = s_axi_arvalid & s_axi_arready;
            b = s_axi_rvalid;
            d = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge clock_i);
            if (ar) s_axi_arvalid <= 1'h0;
            if (b) begin
                s_axi_rready <= 1'h0;
                return;
            end
        end
        hang();
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        rd(a, v, r);
        check(v, e);
    endtask
    // Wait for a pass to end, optionally check its events, then clear them
    task automatic pass_end(input logic chk, input logic err);
        for (int i = 0; i < 2000; i++) begin
            @(negedge clock_i);
            if (irq_o === 1'h1) begin
                rd(IRQ_STATUS_OFFSET, v, r);
                if (chk) check(v, {30'h0, err, 1'h1});
                wr(IRQ_STATUS_OFFSET, 32'h3, r);
                return;
            end
        end
        hang();
    endtask
    function automatic logic [31:0] crc_of();
        logic [31:0] q;
        q = CRC_SEED;
        for (int w = 0; w < WORDS; w++)
            for (int b = 31; b >= 0; b--)
                q = {q[30:0], 1'h0} ^ ((q[31] ^ u_core.mem[w][b]) ? CRC_POLY : 32'h0);
        return q;
    endfunction
    initial begin
        void'($urandom(32'h8d76));
        for (int i = 0; i < WORDS; i++) u_core.mem[i] = $urandom;
        repeat (2) @(posedge clock_i);
        resetn_i <= 1'h1;
        check({error_pin_o, error_pin_oe_o, irq_o}, 32'h0);
        rc(CTRL_OFFSET, CTRL_RESET);
        rc(PRECOMP_OFFSET, PRECOMP_RESET);
        rd(12'h0f0, v, r);
        check(r, RESP_SLVERR);
        wr(12'h0f0, 32'hffff_ffff, r);
        check(r, RESP_SLVERR);
        pre = crc_of();
        wr(PRECOMP_OFFSET, pre, r);
        wr(IRQ_MASK_OFFSET, 32'h3, r);
        n = 4'($urandom_range(3, 2));
        wr(CTRL_OFFSET, {24'h0, n, 4'h1}, r);
        repeat (40) @(posedge clock_i);
        rd(STATUS_OFFSET, v, r);
        check(v[STATUS_BUSY_BIT], 32'h0);
        user_mode_i <= 1'h1;
        pass_end(1'h1, 1'h0);
        check({error_pin_o, error_pin_oe_o}, 32'h1);
        rc(STATUS_OFFSET, 32'h6);
        rc(SIGNATURE_OFFSET, 32'h0);
        u_core.read_word(1'h0, v);
        check(v, pre);
        u_core.read_word(1'h1, v);
        check(v, 32'h0);
        a0 = cfg_addr_o;
        k = 0;
        m = 999;
        for (int t = 0; t < 300; t++) begin
            @(negedge clock_i);
            k++;
            if (cfg_addr_o !== a0) begin
                if (t >= k && k < m) m = k;
                k = 0;
                a0 = cfg_addr_o;
            end
        end
        check(32'(m), 32'h1 << n);
        @(posedge clock_i);
        ce_i <= 1'h0;
        @(negedge clock_i);
        a0 = cfg_addr_o;
        repeat (20) @(negedge clock_i);
        check(cfg_addr_o, a0);
        @(posedge clock_i);
        ce_i <= 1'h1;
        wr(CTRL_OFFSET, 32'h91, r);
        rc(CTRL_OFFSET, {24'h0, n, 4'h1});
        fix = 32'h1 << $urandom_range(31);
        c = $urandom_range(WORDS - 1);
        u_core.mem[c] ^= fix;
        repeat (2) pass_end(1'h0, 1'h0);
        pass_end(1'h1, 1'h1);
        check({error_pin_o, error_pin_oe_o}, 32'h3);
        rc(SIGNATURE_OFFSET, crc_of() ^ pre);
        u_core.read_word(1'h1, v);
        check(v, crc_of() ^ pre);
        wr(CTRL_OFFSET, {24'h0, n, 4'h3}, r);
        repeat (2) @(posedge clock_i);
        check({error_pin_o, error_pin_oe_o}, 32'h0);
        wr(CTRL_OFFSET, {24'h0, n, 4'h1}, r);
        repeat (2) pass_end(1'h0, 1'h0);
        pass_end(1'h1, 1'h1);
        u_core.mem[c] ^= fix;
        repeat (6) begin
            @(negedge clock_i);
            check(error_pin_o, 32'h1);
        end
        repeat (2) pass_end(1'h0, 1'h0);
        pass_end(1'h1, 1'h0);
        check(error_pin_o, 32'h0);
        rc(SIGNATURE_OFFSET, 32'h0);
        wr(IRQ_MASK_OFFSET, 32'h0, r);
        wr(IRQ_STATUS_OFFSET, 32'h3, r);
        repeat (100) @(posedge clock_i);
        check(irq_o, 32'h0);
        rc(IRQ_STATUS_OFFSET, 32'h1);
        results();
    end
endmodule
`default_nettype wire
